// [pkg/nad_pkg.sv]
// Shared constants and operation codes of the nibble datapath
package nad_pkg;

  // Widths
  localparam int DATA_W    = 4;
  localparam int ADDR_W    = 8;
  localparam int GEN_W     = 5;
  localparam int BIT_W     = 2;
  localparam int SFR_IDX_W = 3;
  localparam int SFR_COUNT = 8;

  // Upper bits that place a 5-bit operand in the general half of a page
  localparam logic [2:0] GEN_BASE = 3'h1;

  // Reset values and nibble constants
  localparam logic [3:0] ACC_RESET   = 4'h0;
  localparam logic       CARRY_RESET = 1'h0;
  localparam logic       ZERO_RESET  = 1'h0;
  localparam logic [3:0] SFR_RESET   = 4'h0;
  localparam logic [3:0] ONE         = 4'h1;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  // Operation codes issued by the decoder
  typedef enum logic [4:0] {
    op_nop                  = 5'b00000,
    op_add_mem_carry        = 5'b00001,
    op_add_literal_carry    = 5'b00010,
    op_increment_mem        = 5'b00011,
    op_decrement_mem        = 5'b00100,
    op_xor_mem              = 5'b00101,
    op_rotate_mem_right     = 5'b00110,
    op_rotate_mem_left      = 5'b00111,
    op_store_acc            = 5'b01000,
    op_load_accumulator     = 5'b01001,
    op_and_mem              = 5'b01010,
    op_or_mem               = 5'b01011,
    op_sub_mem_borrow       = 5'b01100,
    op_sub_literal_borrow   = 5'b01101,
    op_bit_clear            = 5'b01110,
    op_bit_set              = 5'b01111,
    op_reg_to_mem_move      = 5'b10000,
    op_mem_to_reg_move      = 5'b10001,
    op_literal_to_reg_move  = 5'b10010,
    op_literal_to_acc       = 5'b10011,
    op_and_literal          = 5'b10100,
    op_or_literal           = 5'b10101,
    op_xor_literal          = 5'b10110,
    op_increment_acc        = 5'b10111,
    op_decrement_acc        = 5'b11000,
    op_rotate_acc_right_carry = 5'b11001,
    op_rotate_acc_left_carry  = 5'b11010,
    op_rotate_acc_right     = 5'b11011,
    op_rotate_acc_left      = 5'b11100,
    op_negate_acc           = 5'b11101,
    op_carry_clear          = 5'b11110,
    op_carry_set            = 5'b11111
  } nad_op_t;

endpackage : nad_pkg

// [hw/nad_alu.sv]
// Combinational result and flag unit of the nibble datapath
`timescale 1ns/1ps
module nad_alu (
  // Operation and operands
  input  wire nad_pkg::nad_op_t op,
  input  wire logic [3:0]       acc,
  input  wire logic [3:0]       operand,
  input  wire logic             carry,
  input  wire logic [1:0]       bit_pos,
  // Result and flag controls
  output logic      [3:0]       result,
  output logic                  carry_out,
  output logic                  carry_we,
  output logic                  zero_we
);

  logic [4:0] sum;

  always_comb
  begin
    sum       = 5'h00;
    result    = acc;
    carry_out = carry;
    carry_we  = 1'b0;
    zero_we   = 1'b0;
    case (op)
      nad_pkg::op_add_mem_carry, nad_pkg::op_add_literal_carry:
      begin
        sum       = {1'b0, acc} + {1'b0, operand} + {4'h0, carry};
        result    = sum[3:0];
        carry_out = sum[4];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_sub_mem_borrow, nad_pkg::op_sub_literal_borrow:
      begin
        sum       = {1'b0, acc} - {1'b0, operand} - {4'h0, ~carry};
        result    = sum[3:0];
        carry_out = ~sum[4];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_increment_mem:
      begin
        sum       = {1'b0, operand} + {1'b0, nad_pkg::ONE};
        result    = sum[3:0];
        carry_out = sum[4];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_decrement_mem:
      begin
        sum       = {1'b0, operand} - {1'b0, nad_pkg::ONE};
        result    = sum[3:0];
        carry_out = ~sum[4];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_increment_acc:
      begin
        sum       = {1'b0, acc} + {1'b0, nad_pkg::ONE};
        result    = sum[3:0];
        carry_out = sum[4];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_decrement_acc:
      begin
        sum       = {1'b0, acc} - {1'b0, nad_pkg::ONE};
        result    = sum[3:0];
        carry_out = ~sum[4];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_rotate_mem_right:
      begin
        result    = {carry, operand[3:1]};
        carry_out = operand[0];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_rotate_mem_left:
      begin
        result    = {operand[2:0], carry};
        carry_out = operand[3];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_rotate_acc_right_carry:
      begin
        result    = {carry, acc[3:1]};
        carry_out = acc[0];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_rotate_acc_left_carry:
      begin
        result    = {acc[2:0], carry};
        carry_out = acc[3];
        carry_we  = 1'b1;
        zero_we   = 1'b1;
      end
      nad_pkg::op_rotate_acc_right:
      begin
        result  = {acc[0], acc[3:1]};
        zero_we = 1'b1;
      end
      nad_pkg::op_rotate_acc_left:
      begin
        result  = {acc[2:0], acc[3]};
        zero_we = 1'b1;
      end
      nad_pkg::op_negate_acc:
      begin
        result  = nad_pkg::NIBBLE_ZERO - acc;
        zero_we = 1'b1;
      end
      nad_pkg::op_xor_mem, nad_pkg::op_xor_literal:
      begin
        result  = acc ^ operand;
        zero_we = 1'b1;
      end
      nad_pkg::op_and_mem, nad_pkg::op_and_literal:
      begin
        result  = acc & operand;
        zero_we = 1'b1;
      end
      nad_pkg::op_or_mem, nad_pkg::op_or_literal:
      begin
        result  = acc | operand;
        zero_we = 1'b1;
      end
      nad_pkg::op_load_accumulator:
      begin
        result  = operand;
        zero_we = 1'b1;
      end
      nad_pkg::op_bit_clear:
        result = operand & ~(4'h1 << bit_pos);
      nad_pkg::op_bit_set:
        result = operand | (4'h1 << bit_pos);
      nad_pkg::op_reg_to_mem_move, nad_pkg::op_mem_to_reg_move,
      nad_pkg::op_literal_to_reg_move, nad_pkg::op_literal_to_acc:
        result = operand;
      nad_pkg::op_carry_clear:
      begin
        carry_out = 1'b0;
        carry_we  = 1'b1;
      end
      nad_pkg::op_carry_set:
      begin
        carry_out = 1'b1;
        carry_we  = 1'b1;
      end
      default:
        result = acc;
    endcase
  end

endmodule : nad_alu

// [hw/nad_datapath.sv]
// Nibble accumulator datapath: flags, register group and memory write-back
// Contract
// - Add with carry from memory or literal; low nibble to accumulator, overflow to carry.
// - Increment memory nibble, write back, update carry and zero.
// - Decrement memory nibble modulo 16, write back, update carry and zero.
// - Exclusive-or memory into accumulator, update zero only.
// - Rotate memory right through carry as five-bit ring, write back.
// - Rotate memory left through carry, write back.
// - Store accumulator leaves flags; load accumulator updates zero.
// - And memory into accumulator, update zero.
// - Subtract operand and inverted carry; carry set when no borrow.
// - Or memory into accumulator.
// - Clear or set one bit of a general location, flags untouched.
// - Five-bit operations reach only locations 0x20 to 0x3f of a page.
// - Moves between register group and general memory leave flags.
// - Literal into indexed register, flags untouched.
// - Literal into accumulator, flags untouched.
// - Literal and, or, xor into accumulator; all three update zero.
// - Increment and decrement accumulator modulo 16, update carry and zero.
// - Plain accumulator rotates without carry, update zero.
// - Accumulator becomes zero minus accumulator, update zero.
// - Carry clear and set touch nothing else.
// - Every operation takes one word and one cycle.
`timescale 1ns/1ps
module nad_datapath #(
  parameter int SFR_COUNT = nad_pkg::SFR_COUNT
) (
  // Clock and reset
  input  wire  logic                    ref_clk,
  input  wire  logic                    nrst,
  // Decoder request
  input  wire  logic                    op_valid,
  input  wire  nad_pkg::nad_op_t        op_code,
  input  wire  logic [7:0]              op_addr,
  input  wire  logic [3:0]              op_literal,
  input  wire  logic [1:0]              op_bit,
  input  wire  logic [2:0]              op_sfr,
  // Data memory
  output logic       [7:0]              mem_raddr,
  input  wire  logic [3:0]              mem_rdata,
  output logic                          mem_we,
  output logic       [7:0]              mem_waddr,
  output logic       [3:0]              mem_wdata,
  // Core state
  output logic       [3:0]              accumulator,
  output logic                          carry_flag,
  output logic                          zero_flag,
  output logic       [4*SFR_COUNT-1:0]  special_function_register,
  output logic                          op_done
);

  logic [3:0]       operand;
  logic [3:0]       fwd_rdata;
  logic [3:0]       sfr_value;
  logic [3:0]       alu_result;
  logic             alu_carry;
  logic             alu_carry_we;
  logic             alu_zero_we;
  nad_pkg::nad_op_t op_eff;

  // Operation picks a short general address
  function automatic logic short_addr(input nad_pkg::nad_op_t op);
    short_addr = (op == nad_pkg::op_bit_clear) || (op == nad_pkg::op_bit_set) ||
                 (op == nad_pkg::op_reg_to_mem_move) || (op == nad_pkg::op_mem_to_reg_move);
  endfunction : short_addr

  // Operation takes the literal as operand
  function automatic logic uses_literal(input nad_pkg::nad_op_t op);
    case (op)
      nad_pkg::op_add_literal_carry, nad_pkg::op_sub_literal_borrow,
      nad_pkg::op_literal_to_reg_move, nad_pkg::op_literal_to_acc,
      nad_pkg::op_and_literal, nad_pkg::op_or_literal, nad_pkg::op_xor_literal:
        uses_literal = 1'b1;
      default:
        uses_literal = 1'b0;
    endcase
  endfunction : uses_literal

  // Operation writes the data memory
  function automatic logic writes_mem(input nad_pkg::nad_op_t op);
    case (op)
      nad_pkg::op_increment_mem, nad_pkg::op_decrement_mem,
      nad_pkg::op_rotate_mem_right, nad_pkg::op_rotate_mem_left,
      nad_pkg::op_store_acc, nad_pkg::op_bit_clear, nad_pkg::op_bit_set,
      nad_pkg::op_reg_to_mem_move:
        writes_mem = 1'b1;
      default:
        writes_mem = 1'b0;
    endcase
  endfunction : writes_mem

  // Operation writes the register group
  function automatic logic writes_sfr(input nad_pkg::nad_op_t op);
    writes_sfr = (op == nad_pkg::op_mem_to_reg_move) || (op == nad_pkg::op_literal_to_reg_move);
  endfunction : writes_sfr

  // Operation writes the accumulator
  function automatic logic writes_acc(input nad_pkg::nad_op_t op);
    case (op)
      nad_pkg::op_add_mem_carry, nad_pkg::op_add_literal_carry, nad_pkg::op_xor_mem,
      nad_pkg::op_load_accumulator, nad_pkg::op_and_mem, nad_pkg::op_or_mem,
      nad_pkg::op_sub_mem_borrow, nad_pkg::op_sub_literal_borrow, nad_pkg::op_literal_to_acc,
      nad_pkg::op_and_literal, nad_pkg::op_or_literal, nad_pkg::op_xor_literal,
      nad_pkg::op_increment_acc, nad_pkg::op_decrement_acc,
      nad_pkg::op_rotate_acc_right_carry, nad_pkg::op_rotate_acc_left_carry,
      nad_pkg::op_rotate_acc_right, nad_pkg::op_rotate_acc_left, nad_pkg::op_negate_acc:
        writes_acc = 1'b1;
      default:
        writes_acc = 1'b0;
    endcase
  endfunction : writes_acc

  assign op_eff = op_valid ? op_code : nad_pkg::op_nop;

  assign mem_raddr = short_addr(op_eff) ? {nad_pkg::GEN_BASE, op_addr[4:0]} : op_addr;

  // Forward last write so back-to-back operations see fresh data
  assign fwd_rdata = (mem_we && (mem_waddr == mem_raddr)) ? mem_wdata : mem_rdata;
  assign sfr_value = special_function_register[4*op_sfr +: 4];

  always_comb
  begin
    if (uses_literal(op_eff))
      operand = op_literal;
    else if (op_eff == nad_pkg::op_reg_to_mem_move)
      operand = sfr_value;
    else if (op_eff == nad_pkg::op_store_acc)
      operand = accumulator;
    else
      operand = fwd_rdata;
  end

  nad_alu u_alu (
    .op        (op_eff),
    .acc       (accumulator),
    .operand   (operand),
    .carry     (carry_flag),
    .bit_pos   (op_bit),
    .result    (alu_result),
    .carry_out (alu_carry),
    .carry_we  (alu_carry_we),
    .zero_we   (alu_zero_we)
  );

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      accumulator <= nad_pkg::ACC_RESET;
    else if (writes_acc(op_eff))
      accumulator <= alu_result;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      carry_flag <= nad_pkg::CARRY_RESET;
    else if (alu_carry_we)
      carry_flag <= alu_carry;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      zero_flag <= nad_pkg::ZERO_RESET;
    else if (alu_zero_we)
      zero_flag <= (alu_result == nad_pkg::NIBBLE_ZERO);
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_we    <= 1'b0;
      mem_waddr <= 8'h00;
      mem_wdata <= 4'h0;
    end
    else
    begin
      mem_we <= writes_mem(op_eff);
      if (writes_mem(op_eff))
      begin
        mem_waddr <= mem_raddr;
        mem_wdata <= alu_result;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      special_function_register <= {SFR_COUNT{nad_pkg::SFR_RESET}};
    else if (writes_sfr(op_eff))
      special_function_register[4*op_sfr +: 4] <= alu_result;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      op_done <= 1'b0;
    else
      op_done <= op_valid;
  end

  // Checks
  sequence s_issue(nad_pkg::nad_op_t code);
    op_valid && (op_code == code);
  endsequence

  sequence s_flags_kept;
    (carry_flag == $past(carry_flag)) && (zero_flag == $past(zero_flag));
  endsequence

  a_add_result: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (s_issue(nad_pkg::op_add_mem_carry) or s_issue(nad_pkg::op_add_literal_carry)) |=>
      ({carry_flag, accumulator} ==
       5'({1'b0, $past(accumulator)} + {1'b0, $past(operand)} + {4'h0, $past(carry_flag)})))
    else $error("add with carry result wrong");

  a_sub_result: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (s_issue(nad_pkg::op_sub_mem_borrow) or s_issue(nad_pkg::op_sub_literal_borrow)) |=>
      (accumulator == 4'($past(accumulator) - $past(operand) - {3'h0, ~$past(carry_flag)})) &&
      (carry_flag == ({1'b0, $past(accumulator)} >= 5'({1'b0, $past(operand)} + {4'h0, ~$past(carry_flag)}))))
    else $error("subtract with borrow wrong");

  a_inc_mem_wb: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_issue(nad_pkg::op_increment_mem) |=>
      mem_we && (mem_waddr == $past(op_addr)) && (mem_wdata == 4'($past(fwd_rdata) + 4'h1)) &&
      (carry_flag == ($past(fwd_rdata) == 4'hf)))
    else $error("increment memory write-back wrong");

  a_dec_mem_wb: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_issue(nad_pkg::op_decrement_mem) |=>
      mem_we && (mem_wdata == 4'($past(fwd_rdata) - 4'h1)) && (carry_flag == ($past(fwd_rdata) != 4'h0)))
    else $error("decrement memory write-back wrong");

  a_rot_mem_ring: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_issue(nad_pkg::op_rotate_mem_right) |=>
      ({mem_wdata, carry_flag} == {$past(carry_flag), $past(fwd_rdata)}))
    else $error("rotate memory right ring wrong");

  a_rot_acc_carry: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_issue(nad_pkg::op_rotate_acc_left_carry) |=>
      ({carry_flag, accumulator} == {$past(accumulator), $past(carry_flag)}))
    else $error("rotate accumulator left through carry wrong");

  a_short_addr: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (s_issue(nad_pkg::op_bit_set) or s_issue(nad_pkg::op_bit_clear)) |=>
      mem_we && (mem_waddr[7:5] == nad_pkg::GEN_BASE) && (mem_waddr[4:0] == $past(op_addr[4:0])) and s_flags_kept)
    else $error("short address outside general half");

  a_literal_acc: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_issue(nad_pkg::op_literal_to_acc) |=> (accumulator == $past(op_literal)) and s_flags_kept)
    else $error("literal move changed flags or value");

  a_zero_exact: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    op_valid && alu_zero_we |=>
      (writes_acc($past(op_eff)) ? (zero_flag == (accumulator == 4'h0)) :
                                   (mem_we && (zero_flag == (mem_wdata == 4'h0)))))
    else $error("zero flag disagrees with result");

  a_sfr_move: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_issue(nad_pkg::op_literal_to_reg_move) |=>
      (special_function_register[4*$past(op_sfr) +: 4] == $past(op_literal)) and s_flags_kept)
    else $error("literal to register move wrong");

  a_done_pulse: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    op_valid |=> op_done)
    else $error("operation not complete in one cycle");

endmodule : nad_datapath

// [verif/nad_mem_model.sv]
// Behavioural data memory on the far side of the nibble datapath
`timescale 1ns/1ps
module nad_mem_model (
  // Clock
  input  wire logic       ref_clk,
  // Read port
  input  wire logic [7:0] mem_raddr,
  output logic      [3:0] mem_rdata,
  // Write port
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_waddr,
  input  wire logic [3:0] mem_wdata
);
  logic [3:0] mem [256];

  // Arbitrary fill (low address nibble xor 5) so that no location reads as unknown
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[3:0] ^ 4'h5;
  end

  // Same-cycle read; a write commits on the edge that sees the strobe
  assign mem_rdata = mem[mem_raddr];

  always @(posedge ref_clk)
  begin
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
  end
endmodule : nad_mem_model

// [verif/tb.sv]
// Self-checking bench of the nibble datapath
`timescale 1ns/1ps
module tb;
  // Design ports
  logic             ref_clk    = 1'b0;
  logic             nrst       = 1'b0;
  logic             op_valid   = 1'b0;
  nad_pkg::nad_op_t op_code    = nad_pkg::op_nop;
  logic [7:0]       op_addr    = 8'h00;
  logic [3:0]       op_literal = 4'h0;
  logic [1:0]       op_bit     = 2'h0;
  logic [2:0]       op_sfr     = 3'h0;
  logic [7:0]       mem_raddr, mem_waddr;
  logic [3:0]       mem_rdata, mem_wdata, accumulator;
  logic             mem_we, carry_flag, zero_flag, op_done;
  logic [31:0]      special_function_register;
  // Expected state
  logic [3:0]       e_acc, e_sfr [8], e_mem [256];
  logic             e_c, e_z;
  int               err_count = 0;
  int               checks    = 0;
  // Fields: acc, carry, memory, literal, bit, index, address
  localparam logic [31:0] VEC [4] = '{32'h70aa2245, 32'h01ff37fe, 32'hb1000000, 32'h31e5153c};

  always #2.5 ref_clk = ~ref_clk;

  nad_datapath nad_datapath_inst (.*);
  nad_mem_model nad_mem_model_inst (.*);

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  function automatic logic gen(input nad_pkg::nad_op_t op);
    return op inside {nad_pkg::op_bit_clear, nad_pkg::op_bit_set, nad_pkg::op_reg_to_mem_move,
                      nad_pkg::op_mem_to_reg_move};
  endfunction : gen

  task automatic apply(input nad_pkg::nad_op_t op, input logic [7:0] ad, input logic [3:0] l,
                       input logic [1:0] b, input logic [2:0] r);
    logic [7:0] ea;
    logic [3:0] m, o, a, md;
    logic       c, zu, mz, mw;
    ea = gen(op) ? {3'h1, ad[4:0]} : ad;
    m  = e_mem[ea];
    o  = (op inside {nad_pkg::op_add_literal_carry, nad_pkg::op_sub_literal_borrow, nad_pkg::op_and_literal,
                     nad_pkg::op_or_literal, nad_pkg::op_xor_literal}) ? l : m;
    a  = e_acc;
    c  = e_c;
    md = m;
    {zu, mz, mw} = 3'h0;
    case (op)
      nad_pkg::op_add_mem_carry, nad_pkg::op_add_literal_carry: {c, a, zu} = {{1'b0, e_acc} + o + e_c, 1'b1};
      nad_pkg::op_sub_mem_borrow, nad_pkg::op_sub_literal_borrow:
        {c, a, zu} = {{1'b0, e_acc} >= {1'b0, o} + !e_c, e_acc - o - !e_c, 1'b1};
      nad_pkg::op_increment_mem: {mw, c, md, mz} = {1'b1, {1'b0, m} + 5'h01, 1'b1};
      nad_pkg::op_decrement_mem: {mw, c, md, mz} = {1'b1, m != 4'h0, m - 4'h1, 1'b1};
      nad_pkg::op_rotate_mem_right: {mw, md, c, mz} = {1'b1, e_c, m, 1'b1};
      nad_pkg::op_rotate_mem_left: {mw, c, md, mz} = {1'b1, m, e_c, 1'b1};
      nad_pkg::op_store_acc: {mw, md} = {1'b1, e_acc};
      nad_pkg::op_load_accumulator: {a, zu} = {m, 1'b1};
      nad_pkg::op_xor_mem, nad_pkg::op_xor_literal: {a, zu} = {e_acc ^ o, 1'b1};
      nad_pkg::op_and_mem, nad_pkg::op_and_literal: {a, zu} = {e_acc & o, 1'b1};
      nad_pkg::op_or_mem, nad_pkg::op_or_literal: {a, zu} = {e_acc | o, 1'b1};
      nad_pkg::op_bit_clear: {mw, md} = {1'b1, m & ~(4'h1 << b)};
      nad_pkg::op_bit_set: {mw, md} = {1'b1, m | (4'h1 << b)};
      nad_pkg::op_reg_to_mem_move: {mw, md} = {1'b1, e_sfr[r]};
      nad_pkg::op_mem_to_reg_move: e_sfr[r] = m;
      nad_pkg::op_literal_to_reg_move: e_sfr[r] = l;
      nad_pkg::op_literal_to_acc: a = l;
      nad_pkg::op_increment_acc: {c, a, zu} = {{1'b0, e_acc} + 5'h01, 1'b1};
      nad_pkg::op_decrement_acc: {c, a, zu} = {e_acc != 4'h0, e_acc - 4'h1, 1'b1};
      nad_pkg::op_rotate_acc_right_carry: {a, c, zu} = {e_c, e_acc, 1'b1};
      nad_pkg::op_rotate_acc_left_carry: {c, a, zu} = {e_acc, e_c, 1'b1};
      nad_pkg::op_rotate_acc_right: {a, zu} = {e_acc[0], e_acc[3:1], 1'b1};
      nad_pkg::op_rotate_acc_left: {a, zu} = {e_acc[2:0], e_acc[3], 1'b1};
      nad_pkg::op_negate_acc: {a, zu} = {4'h0 - e_acc, 1'b1};
      nad_pkg::op_carry_clear: c = 1'b0;
      nad_pkg::op_carry_set: c = 1'b1;
      default: a = e_acc;
    endcase
    e_z   = zu ? (a == 4'h0) : (mz ? (md == 4'h0) : e_z);
    e_acc = a;
    e_c   = c;
    if (mw)
      e_mem[ea] = md;
    op_valid   = 1'b1;
    op_code    = op;
    op_addr    = ad;
    op_literal = l;
    op_bit     = b;
    op_sfr     = r;
    #1;
    check("read address", mem_raddr, ea);
    @(posedge ref_clk);
    #1;
    check("accumulator", accumulator, e_acc);
    check("carry", carry_flag, e_c);
    check("zero", zero_flag, e_z);
    check("done", op_done, 8'h01);
    check("write strobe", mem_we, mw);
    if (mw)
    begin
      check("write address", mem_waddr, ea);
      check("write data", mem_wdata, md);
    end
    for (int i = 0; i < 8; i++)
      check("register", special_function_register[4*i +: 4], e_sfr[i]);
  endtask : apply

  task automatic idle;
    op_valid = 1'b0;
    op_code  = nad_pkg::op_increment_mem;
    @(posedge ref_clk);
    #1;
    check("idle done", op_done, 8'h00);
    check("idle strobe", mem_we, 8'h00);
  endtask : idle

  task automatic poke(input logic [7:0] a, input logic [3:0] v);
    nad_mem_model_inst.mem[a] = v;
    e_mem[a] = v;
  endtask : poke

  task automatic run_vec(input nad_pkg::nad_op_t op, input int v);
    logic [31:0] w;
    logic [7:0]  ea;
    w  = VEC[v];
    ea = gen(op) ? {3'h1, w[4:0]} : w[7:0];
    poke(ea, w[23:20]);
    apply(nad_pkg::op_literal_to_acc, 8'h00, w[31:28], 2'h0, 3'h0);
    apply(w[24] ? nad_pkg::op_carry_set : nad_pkg::op_carry_clear, 8'h00, 4'h0, 2'h0, 3'h0);
    apply(op, w[7:0], w[19:16], w[13:12], w[10:8]);
    idle;
    check("memory", nad_mem_model_inst.mem[ea], e_mem[ea]);
  endtask : run_vec

  task automatic run_set(input string name, input nad_pkg::nad_op_t ops[$]);
    foreach (ops[i])
      for (int v = 0; v < 4; v++)
        run_vec(ops[i], v);
    $display("Test %s done, mismatches so far %0d", name, err_count);
  endtask : run_set

  task automatic t_reset;
    e_acc = 4'h0;
    e_c   = 1'b0;
    e_z   = 1'b0;
    foreach (e_sfr[i])
      e_sfr[i] = 4'h0;
    foreach (e_mem[i])
      e_mem[i] = nad_mem_model_inst.mem[i];
    check("reset accumulator", accumulator, 8'h00);
    check("reset flags", {carry_flag, zero_flag, op_done, mem_we}, 8'h00);
    check("reset registers", {7'h00, |special_function_register}, 8'h00);
  endtask : t_reset

  task automatic t_sfr;
    for (int i = 0; i < 8; i++)
      apply(nad_pkg::op_literal_to_reg_move, 8'h00, 4'(i + 9), 2'h0, 3'(i));
    idle;
    run_set("register moves", {nad_pkg::op_reg_to_mem_move, nad_pkg::op_mem_to_reg_move,
                               nad_pkg::op_bit_clear, nad_pkg::op_bit_set});
  endtask : t_sfr

  task automatic t_b2b;
    poke(8'h81, 4'hf);
    apply(nad_pkg::op_increment_mem, 8'h81, 4'h0, 2'h0, 3'h0);
    apply(nad_pkg::op_increment_mem, 8'h81, 4'h0, 2'h0, 3'h0);
    apply(nad_pkg::op_load_accumulator, 8'h81, 4'h0, 2'h0, 3'h0);
    idle;
    check("memory", nad_mem_model_inst.mem[8'h81], 8'h01);
    $display("Test back to back done, mismatches so far %0d", err_count);
  endtask : t_b2b

  task automatic t_mid_reset;
    apply(nad_pkg::op_literal_to_acc, 8'h00, 4'h9, 2'h0, 3'h0);
    nrst = 1'b0;
    #1;
    t_reset();
    repeat (2) @(posedge ref_clk);
    #1;
    op_valid = 1'b0;
    nrst     = 1'b1;
    idle;
    t_reset();
    $display("Test mid-run reset done, mismatches so far %0d", err_count);
  endtask : t_mid_reset

  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    t_reset();
    $display("Test reset done, mismatches so far %0d", err_count);
    t_sfr();
    run_set("arithmetic", {nad_pkg::op_add_mem_carry, nad_pkg::op_add_literal_carry, nad_pkg::op_sub_mem_borrow,
                           nad_pkg::op_sub_literal_borrow, nad_pkg::op_increment_acc, nad_pkg::op_decrement_acc,
                           nad_pkg::op_negate_acc, nad_pkg::op_nop});
    run_set("logic", {nad_pkg::op_xor_mem, nad_pkg::op_and_mem, nad_pkg::op_or_mem, nad_pkg::op_load_accumulator,
                      nad_pkg::op_and_literal, nad_pkg::op_or_literal, nad_pkg::op_xor_literal});
    run_set("rotate", {nad_pkg::op_rotate_acc_right_carry, nad_pkg::op_rotate_acc_left_carry,
                       nad_pkg::op_rotate_acc_right, nad_pkg::op_rotate_acc_left,
                       nad_pkg::op_rotate_mem_right, nad_pkg::op_rotate_mem_left});
    run_set("memory write", {nad_pkg::op_increment_mem, nad_pkg::op_decrement_mem, nad_pkg::op_store_acc});
    t_b2b();
    t_mid_reset();
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end
endmodule : tb
